// ===== core/sdas_params.svh
// sdram access sequencer constants
// assumes inclusion from the sequencer module only
`ifndef SDAS_PARAMS_SVH
`define SDAS_PARAMS_SVH
`define SDAS_PAGE_WORDS 256
`define SDAS_REFRESH_CYCLES 3700
`define SDAS_TRAS_CYCLES 5
`define SDAS_TRP_CYCLES 2
`define SDAS_CAS_LATENCY 2
`define SDAS_ACT_TO_CMD 2
`define SDAS_BEATS 2
`define SDAS_DATA_W 64
`define SDAS_CLOCK_MHZ 200
`define SDAS_APB_CFG 12'h000
`define SDAS_APB_STATUS 12'h004
`define SDAS_APB_ERR_DATA 32'hDEADBEEF
`define SDAS_CFG_CL_LSB 6
`define SDAS_CFG_CL_W 2
`define SDAS_CFG_CFG_RST 32'h00005983
`endif

// ===== core/sdas_pkg.sv
// types for the sdram access sequencer
// assumes the params header is on the include path
package sdas_pkg;
  typedef enum logic [2:0] {
    SDAS_CMD_NOP,
    SDAS_CMD_ACT,
    SDAS_CMD_RD,
    SDAS_CMD_WR
  } sdas_cmd_e;
  typedef enum logic [1:0] {
    SDAS_ST_IDLE,
    SDAS_ST_ACTWAIT,
    SDAS_ST_OPEN
  } sdas_state_e;
endpackage

// ===== core/sdas_sequencer.sv
// sdram access sequencer: act, nop, rd/wr every second cycle, two beats per command
// assumes one clock shared with the sdram and apb; requesters hold request until ack
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sdas_params.svh"

// Operation
// - only cas latency comes from the timing config; page size, refresh, row-active and precharge are unused.
// - all commands and data run on the single external port clock.
// - every data beat is one 64-bit word.
// - a read issues act, nop, then rd two cycles later, with data cl and cl+1 cycles after rd.
// - sequential reads in an open row issue rd every second cycle giving one word per clock.
// - non-sequential reads in the open row are sequenced like sequential ones.
// - one unrelated core operation in a read stream neither breaks the access nor reactivates.
// - heavier core activity may lower throughput with no guarantee.
// - sequential writes in an open row issue wr every second cycle with two beats each.
// - non-sequential writes in the open row are sequenced like sequential ones.
// - one extra core operation in a write stream does not interrupt it.
module sdas_sequencer import sdas_pkg::*; #(
  parameter int DATA_W = `SDAS_DATA_W,
  parameter int ADDR_W = 24,
  parameter int ROW_LSB = 8
) (
  input wire logic clock, // 200 mhz clock, also sdram clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic req_valid, // core or io_processor_requester request
  input wire logic req_write, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr, // word address of pair
  input wire logic [2*DATA_W-1:0] req_wdata, // two write words, low first
  input wire logic core_busy, // unrelated core operation this cycle
  output logic req_stall, // internal acknowledge stall
  output logic rsp_valid, // read pair delivered, one cycle
  output logic [2*DATA_W-1:0] rsp_rdata, // two read words, low first
  output logic [2:0] sd_cmd, // sdram command code
  output logic [ADDR_W-1:0] sd_addr, // sdram address
  output logic [DATA_W-1:0] sd_dq_o, // write data
  output logic sd_dq_oe_n, // low while driving dq
  input wire logic [DATA_W-1:0] sd_dq_i, // read data from sdram pins
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error
);
  localparam int CL_MAX = 3;
  initial begin
    if (DATA_W != `SDAS_DATA_W || ROW_LSB >= ADDR_W) begin
      $error("sdas_sequencer: unsupported parameters");
    end
  end

  // timing config register
  logic [31:0] sdram_timing_config_ff, nxt_sdram_timing_config;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  sdas_state_e state_ff, nxt_state;
  logic row_open_ff, nxt_row_open;
  logic apb_acc;
  assign apb_acc = psel && penable;
  always_comb begin
    nxt_sdram_timing_config = sdram_timing_config_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == `SDAS_APB_CFG) begin
        nxt_prdata = sdram_timing_config_ff;
      end else if (paddr == `SDAS_APB_STATUS) begin
        nxt_prdata = {29'h0, row_open_ff, state_ff};
      end else begin
        nxt_prdata = `SDAS_APB_ERR_DATA;
        nxt_pslverr = 1'b1;
      end
    end else if (apb_acc) begin
      nxt_pslverr = pslverr_ff;
      if (pwrite && paddr == `SDAS_APB_CFG) begin
        nxt_sdram_timing_config = pwdata;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sdram_timing_config_ff <= `SDAS_CFG_CFG_RST;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      sdram_timing_config_ff <= nxt_sdram_timing_config;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end
  assign pready = apb_acc;
  assign prdata = prdata_ff;
  assign pslverr = apb_acc && pslverr_ff;

  function automatic logic [1:0] cas_lat(input logic [31:0] cfg);
    logic [1:0] v;
    v = cfg[`SDAS_CFG_CL_LSB +: `SDAS_CFG_CL_W];
    if (v < 2'd2) v = 2'd2;
    return v;
  endfunction

  // command sequencer
  logic wr_pend_ff, nxt_wr_pend;
  logic [2:0] sd_cmd_ff, nxt_sd_cmd;
  logic [ADDR_W-1:0] sd_addr_ff, nxt_sd_addr;
  logic [ADDR_W-ROW_LSB-1:0] row_ff, nxt_row;
  logic phase_ff, nxt_phase;
  logic [DATA_W-1:0] wbeat2_ff, nxt_wbeat2;
  logic [DATA_W-1:0] sd_dq_o_ff, nxt_sd_dq_o;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic accept;
  logic same_row;
  assign same_row = row_open_ff && (req_addr[ADDR_W-1:ROW_LSB] == row_ff);
  always_comb begin
    nxt_state = state_ff;
    nxt_sd_cmd = SDAS_CMD_NOP;
    nxt_sd_addr = sd_addr_ff;
    nxt_row = row_ff;
    nxt_row_open = row_open_ff;
    nxt_phase = 1'b0;
    nxt_wbeat2 = wbeat2_ff;
    nxt_sd_dq_o = sd_dq_o_ff;
    nxt_dq_oe_n = 1'b1;
    accept = 1'b0;
    case (state_ff)
      SDAS_ST_IDLE: begin
        if (req_valid && !same_row) begin
          nxt_sd_cmd = SDAS_CMD_ACT;
          nxt_sd_addr = req_addr;
          nxt_row = req_addr[ADDR_W-1:ROW_LSB];
          nxt_row_open = 1'b1;
          nxt_state = SDAS_ST_ACTWAIT;
        end else if (req_valid) begin
          nxt_state = SDAS_ST_OPEN;
        end
      end
      SDAS_ST_ACTWAIT: begin
        nxt_state = SDAS_ST_OPEN; // one nop, then command
      end
      SDAS_ST_OPEN: begin
        if (phase_ff) begin
          // idle command slot; second beat only after a write
          if (wr_pend_ff) begin
            nxt_sd_dq_o = wbeat2_ff;
            nxt_dq_oe_n = 1'b0;
          end
        end else if (req_valid && same_row) begin
          // core_busy does not break the stream same flow any order
          accept = 1'b1;
          nxt_sd_cmd = req_write ? SDAS_CMD_WR : SDAS_CMD_RD;
          nxt_sd_addr = req_addr;
          nxt_phase = 1'b1;
          if (req_write) begin
            nxt_sd_dq_o = req_wdata[DATA_W-1:0];
            nxt_dq_oe_n = 1'b0;
            nxt_wbeat2 = req_wdata[2*DATA_W-1:DATA_W];
          end
        end else if (req_valid) begin
          nxt_row_open = 1'b0;
          nxt_state = SDAS_ST_IDLE;
        end
      end
      default: nxt_state = SDAS_ST_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff <= SDAS_ST_IDLE;
      sd_cmd_ff <= SDAS_CMD_NOP;
      sd_addr_ff <= '0;
      row_ff <= '0;
      row_open_ff <= 1'b0;
      phase_ff <= 1'b0;
      wbeat2_ff <= '0;
      sd_dq_o_ff <= '0;
      dq_oe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      sd_cmd_ff <= nxt_sd_cmd;
      sd_addr_ff <= nxt_sd_addr;
      row_ff <= nxt_row;
      row_open_ff <= nxt_row_open;
      phase_ff <= nxt_phase;
      wbeat2_ff <= nxt_wbeat2;
      sd_dq_o_ff <= nxt_sd_dq_o;
      dq_oe_n_ff <= nxt_dq_oe_n;
    end
  end
  assign sd_cmd = sd_cmd_ff; // all on one clock
  assign sd_addr = sd_addr_ff;
  assign sd_dq_o = sd_dq_o_ff;
  assign sd_dq_oe_n = dq_oe_n_ff;

  // read return: pipe of read issue, beats at cl and cl+1 after rd
  logic [CL_MAX+2:0] rd_pipe_ff, nxt_rd_pipe;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic [DATA_W-1:0] beat1_ff, nxt_beat1;
  logic [2*DATA_W-1:0] rsp_rdata_ff, nxt_rsp_rdata;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [1:0] cl;
  assign cl = cas_lat(sdram_timing_config_ff);
  always_comb begin
    nxt_rd_pipe = {rd_pipe_ff[CL_MAX+1:0], (sd_cmd_ff == SDAS_CMD_RD)};
    nxt_beat1 = beat1_ff;
    nxt_rsp_rdata = rsp_rdata_ff;
    nxt_rsp_valid = 1'b0;
    nxt_wr_pend = accept && req_write;
    // two sync stages on dq add two to cas latency
    if (rd_pipe_ff[3'(cl) + 3'd1]) begin
      nxt_beat1 = dq_s2_ff;
    end
    if (rd_pipe_ff[3'(cl) + 3'd2]) begin
      nxt_rsp_rdata = {dq_s2_ff, beat1_ff};
      nxt_rsp_valid = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_pipe_ff <= '0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      beat1_ff <= '0;
      rsp_rdata_ff <= '0;
      rsp_valid_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
    end else begin
      rd_pipe_ff <= nxt_rd_pipe;
      dq_s1_ff <= sd_dq_i;
      dq_s2_ff <= dq_s1_ff;
      beat1_ff <= nxt_beat1;
      rsp_rdata_ff <= nxt_rsp_rdata;
      rsp_valid_ff <= nxt_rsp_valid;
      wr_pend_ff <= nxt_wr_pend;
    end
  end
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  // stall until the command is issued core_busy does not delay the requester
  // reads release at issue so rd can follow every second cycle
  assign req_stall = req_valid && !accept;

  sequence act_then_nop;
    (sd_cmd == SDAS_CMD_ACT) ##1 (sd_cmd == SDAS_CMD_NOP);
  endsequence
  act_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    act_then_nop |-> ##1 (sd_cmd inside {SDAS_CMD_RD, SDAS_CMD_WR, SDAS_CMD_NOP}))
    else $error("command after act nop wrong");
  cmd_spacing_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd inside {SDAS_CMD_RD, SDAS_CMD_WR}) |=> (sd_cmd == SDAS_CMD_NOP))
    else $error("rd or wr not followed by nop");
  wr_beats_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_WR) |-> !sd_dq_oe_n ##1 !sd_dq_oe_n)
    else $error("write beats not driven");
  no_reopen_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == SDAS_ST_OPEN && core_busy && req_valid && same_row) |=>
    (sd_cmd != SDAS_CMD_ACT))
    else $error("row reactivated in stream");
  rd_data_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_RD && cl == 2'd2) |-> ##6 rsp_valid)
    else $error("read pair late");
  act_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_ACT) |-> ##2 (sd_cmd inside {SDAS_CMD_RD, SDAS_CMD_WR}))
    else $error("no access command two cycles after act");

  // write beats follow the request words
  wr_beat1_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_WR) |-> (sd_dq_o == $past(req_wdata[DATA_W-1:0])))
    else $error("first write beat wrong");
  wr_beat2_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_WR) |=> (sd_dq_o == $past(req_wdata[2*DATA_W-1:DATA_W], 2)))
    else $error("second write beat wrong");

  // dq stays released around a read
  sequence dq_released;
    sd_dq_oe_n ##1 sd_dq_oe_n;
  endsequence
  rd_float_a: assert property (@(posedge clock) disable iff (!nrst)
    (sd_cmd == SDAS_CMD_RD) |-> dq_released)
    else $error("dq driven during read");
  rsp_gap_a: assert property (@(posedge clock) disable iff (!nrst)
    rsp_valid |=> !rsp_valid)
    else $error("read pairs closer than two cycles");

  // requester side
  stall_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (req_valid && !accept) |-> req_stall)
    else $error("request released before issue");
  idle_nop_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == SDAS_ST_IDLE && !req_valid) |=> (sd_cmd == SDAS_CMD_NOP))
    else $error("command issued without request");

  // register side
  cfg_write_a: assert property (@(posedge clock) disable iff (!nrst)
    (apb_acc && pwrite && paddr == `SDAS_APB_CFG) |=>
    (sdram_timing_config_ff == $past(pwdata)))
    else $error("timing config not written");
  unmapped_err_a: assert property (@(posedge clock) disable iff (!nrst)
    (apb_acc && paddr != `SDAS_APB_CFG && paddr != `SDAS_APB_STATUS) |->
    pslverr)
    else $error("unmapped access without error");
endmodule // sdas_sequencer

// ===== dv/sdas_sdram_model.sv
// behavioural sdram: keeps written beats, returns read beats cl cycles after rd
// assumes cl of 2 and registered command and data outputs of the sequencer
`timescale 1ns/1ps
module sdas_sdram_model import sdas_pkg::*; (
  input wire logic clock, // shared clock
  input wire logic [2:0] sd_cmd, // command code
  input wire logic [23:0] sd_addr, // address
  input wire logic [63:0] sd_dq_o, // write data
  input wire logic sd_dq_oe_n, // low while driven
  output logic [63:0] sd_dq_i // read data
);
  logic [63:0] mem [logic [24:0]];
  logic [2:0] rd_sh = 3'h0;
  logic wr_d = 1'b0;
  logic [23:0] a_rd;
  logic [23:0] a_wr;
  initial sd_dq_i = 64'h0;
  // unwritten places give a pattern built from the address
  function automatic logic [63:0] fetch(input logic [24:0] k);
    return mem.exists(k) ? mem[k] : {39'h0, k};
  endfunction
  always @(posedge clock) begin
    rd_sh <= {rd_sh[1:0], sd_cmd == SDAS_CMD_RD};
    wr_d <= sd_cmd == SDAS_CMD_WR;
    if (sd_cmd == SDAS_CMD_RD) a_rd <= sd_addr;
    if (sd_cmd == SDAS_CMD_WR) a_wr <= sd_addr;
    if (sd_cmd == SDAS_CMD_WR && !sd_dq_oe_n) mem[{sd_addr, 1'b0}] = sd_dq_o;
    if (wr_d && !sd_dq_oe_n) mem[{a_wr, 1'b1}] = sd_dq_o;
    // released bus shows the inverse of the last value
    if (rd_sh[0]) sd_dq_i <= fetch({a_rd, 1'b0});
    else if (rd_sh[1]) sd_dq_i <= fetch({a_rd, 1'b1});
    else sd_dq_i <= ~sd_dq_i;
  end
endmodule // sdas_sdram_model

// ===== dv/testbench.sv
// self-checking bench for the sdram access sequencer
// assumes the sdram model file and the design package are compiled first
`timescale 1ns/1ps
module testbench import sdas_pkg::*; ;
  logic clock;
  logic nrst;
  logic req_valid;
  logic req_write;
  logic [23:0] req_addr;
  logic [127:0] req_wdata;
  logic core_busy;
  logic req_stall;
  logic rsp_valid;
  logic [127:0] rsp_rdata;
  logic [2:0] sd_cmd;
  logic [23:0] sd_addr;
  logic [63:0] sd_dq_o;
  logic sd_dq_oe_n;
  logic [63:0] sd_dq_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int ct[$];
  logic [2:0] cc[$];
  logic [127:0] rq[$];
  logic [23:0] a[4];
  logic [127:0] d[4];
  logic [31:0] r;
  logic e;
  sdas_sequencer u_sdas_sequencer (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .core_busy(core_busy), .req_stall(req_stall), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .sd_cmd(sd_cmd), .sd_addr(sd_addr), .sd_dq_o(sd_dq_o),
    .sd_dq_oe_n(sd_dq_oe_n), .sd_dq_i(sd_dq_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sdas_sdram_model u_sdas_sdram_model (.clock(clock), .sd_cmd(sd_cmd), .sd_addr(sd_addr),
    .sd_dq_o(sd_dq_o), .sd_dq_oe_n(sd_dq_oe_n), .sd_dq_i(sd_dq_i));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      fails++;
      finish_test();
    end
    if (sd_cmd !== SDAS_CMD_NOP) begin
      ct.push_back(cyc);
      cc.push_back(sd_cmd);
    end
    if (rsp_valid === 1'b1) rq.push_back(rsp_rdata);
  end
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // request stays up after acceptance; idle drops it
  task automatic req(input logic w, input logic [23:0] ad, input logic [127:0] wd);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= wd;
    core_busy <= 1'($urandom);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_stall !== 1'b0 && n < 40);
  endtask
  task automatic idle();
    req_valid <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  task automatic cmds(input int act, input logic [2:0] op, input int n, input int gap);
    chk(cc.size(), n + act);
    if (act == 1) chk({cc[0], 32'(ct[1] - ct[0])}, {SDAS_CMD_ACT, 32'h2});
    for (int i = 0; i < n; i++) begin
      chk(cc[i + act], op);
      if (gap > 0 && i > 0) chk(ct[i + act] - ct[i + act - 1], gap);
    end
    ct.delete();
    cc.delete();
  endtask
  initial begin
    void'($urandom(32'h51e5));
    nrst = 1'b0;
    {req_valid, req_write, req_addr, req_wdata, core_busy} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk({e, r}, {1'b0, 32'h5983});
    apb(1'b1, 12'h000, 32'h5983);
    apb(1'b0, 12'h008, 32'h0);
    chk({e, r}, {1'b1, 32'hDEADBEEF});
    for (int i = 0; i < 4; i++) begin
      a[i] = {16'h0012, 8'(i * 4 + $urandom_range(3))};
      d[i] = {$urandom, $urandom, $urandom, $urandom};
      req(1'b1, a[i], d[i]);
    end
    idle();
    cmds(1, SDAS_CMD_WR, 4, 2);
    for (int i = 0; i < 4; i++) req(1'b0, a[3 - i], 128'h0);
    idle();
    cmds(0, SDAS_CMD_RD, 4, 2);
    for (int i = 0; i < 4; i++) chk(rq[i], d[3 - i]);
    rq.delete();
    req(1'b0, 24'h034510, 128'h0);
    idle();
    cmds(1, SDAS_CMD_RD, 1, 0);
    chk(rq[0], {39'h0, 24'h034510, 1'b1, 39'h0, 24'h034510, 1'b0});
    apb(1'b0, 12'h004, 32'h0);
    chk({e, r}, {1'b0, 32'h6});
    finish_test();
  end
endmodule // testbench
